//--- tfs_top.sv
// Purpose: channel 0 capture trigger select, interval/overflow/capture flags
// Assumes: pins async to core clock, channel 1 match is core-clock logic
// Notes:   counter, capture registers and interrupt enables live here too
//
// Design decisions made here: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tfs_top #(
  parameter int CNT_W = tfs_pkg::CNT_W
) (
  input  wire logic                       core_clk_i,
  input  wire logic                       rst_i,
  input  wire logic [tfs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [tfs_pkg::DATA_W-1:0] wdata_i,
  input  wire logic                       wr_i,
  input  wire logic                       rd_i,
  output logic      [tfs_pkg::DATA_W-1:0] rdata_o,
  input  wire logic                       hw_standby_i,
  input  wire logic                       capture_pin_a_i,
  input  wire logic                       capture_pin_b_i,
  input  wire logic                       capture_pin_c_i,
  input  wire logic                       capture_pin_d_i,
  input  wire logic                       ch1_match_trigger_i,
  output logic      [CNT_W-1:0]           ch0_counter_o,
  output logic      [CNT_W-1:0]           ch0_capture_reg_a_o,
  output logic      [CNT_W-1:0]           ch0_capture_reg_b_o,
  output logic      [CNT_W-1:0]           ch0_capture_reg_c_o,
  output logic      [CNT_W-1:0]           ch0_capture_reg_d_o,
  output logic                            irq_o
);
  localparam int CN = tfs_pkg::CAP_N;
  localparam int IN = tfs_pkg::ITV_N;

  logic [7:0]       capture_trigger_select;
  logic [7:0]       interval_enable_reg;
  logic [7:0]       irq_enable_hi;
  logic [7:0]       irq_enable_lo;
  logic             sw_standby;
  logic [CNT_W-1:0] ch0_counter;
  logic [CN-1:0]    pin_s1;
  logic [CN-1:0]    pin_s2;
  logic [CN-1:0]    pin_s3;
  logic [IN-1:0]    itv_and_q;
  logic [IN-1:0]    interval_flag;
  logic [CN-1:0]    capture_flag;
  logic             ch0_overflow_flag;
  logic             ch1_trig_q;
  logic [CNT_W-1:0] cap_reg [CN];

  wire standby = hw_standby_i | sw_standby;
  wire wr_trig = wr_i & (addr_i == tfs_pkg::OFS_TRIG_SEL);
  wire wr_itv  = wr_i & (addr_i == tfs_pkg::OFS_ITV_STAT);
  wire wr_cap  = wr_i & (addr_i == tfs_pkg::OFS_CAP_STAT);
  wire rd_itv  = rd_i & (addr_i == tfs_pkg::OFS_ITV_STAT);
  wire rd_cap  = rd_i & (addr_i == tfs_pkg::OFS_CAP_STAT);

  // rising edges only: pin edges capture, except pins a and d while their select bit picks channel 1
  wire [CN-1:0] pin_edge = pin_s2 & ~pin_s3;
  wire          ch1_edge = ch1_match_trigger_i & ~ch1_trig_q;
  wire          sel_a    = capture_trigger_select[tfs_pkg::BIT_TRIG_A];
  wire          sel_d    = capture_trigger_select[tfs_pkg::BIT_TRIG_D];
  wire [CN-1:0] cap_evt;
  assign cap_evt[0] = sel_a ? ch1_edge : pin_edge[0];
  assign cap_evt[1] = pin_edge[1];
  assign cap_evt[2] = pin_edge[2];
  assign cap_evt[3] = sel_d ? ch1_edge : pin_edge[3];

  wire [CNT_W-1:0] next_counter = ch0_counter + CNT_W'(tfs_pkg::CNT_ONE);
  wire             ovf_evt      = (ch0_counter == CNT_W'(tfs_pkg::CNT_ONES)) & ~standby;

  wire [IN-1:0] itv_and = interval_enable_reg[IN-1:0]
                        & ch0_counter[tfs_pkg::ITV_BIT_BASE +: IN];
  // bit k of the and pairs enable k with counter bit 10+k
  wire [IN-1:0] itv_evt = itv_and & ~itv_and_q;

  wire [7:0] itv_stat_rd = {4'h0, interval_flag} & tfs_pkg::MASK_ITV;
  wire [7:0] cap_stat_rd = {3'h0, ch0_overflow_flag, capture_flag} & tfs_pkg::MASK_CAP;
  wire [7:0] trig_rd     = capture_trigger_select & tfs_pkg::MASK_TRIG;

  // widened first, so a narrower counter reads zero in its upper bytes
  wire [31:0] cnt_wide = 32'(ch0_counter);
  wire [7:0]  cnt_byte [4];
  assign cnt_byte[0] = cnt_wide[7:0];
  assign cnt_byte[1] = cnt_wide[15:8];
  assign cnt_byte[2] = cnt_wide[23:16];
  assign cnt_byte[3] = cnt_wide[31:24];

  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = tfs_pkg::RESET_BYTE;
    unique case (addr_i)
      tfs_pkg::OFS_TRIG_SEL:  next_rdata = trig_rd;
      tfs_pkg::OFS_ITV_STAT:  next_rdata = itv_stat_rd;
      tfs_pkg::OFS_CAP_STAT:  next_rdata = cap_stat_rd;
      tfs_pkg::OFS_ITV_EN:    next_rdata = interval_enable_reg;
      tfs_pkg::OFS_IRQ_EN_HI: next_rdata = irq_enable_hi;
      tfs_pkg::OFS_IRQ_EN_LO: next_rdata = irq_enable_lo;
      tfs_pkg::OFS_COUNT0:    next_rdata = cnt_byte[0];
      tfs_pkg::OFS_COUNT1:    next_rdata = cnt_byte[1];
      tfs_pkg::OFS_COUNT2:    next_rdata = cnt_byte[2];
      tfs_pkg::OFS_COUNT3:    next_rdata = cnt_byte[3];
      tfs_pkg::OFS_STANDBY:   next_rdata = {7'h00, sw_standby};
      default:                next_rdata = tfs_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= tfs_pkg::RESET_BYTE;
    end else begin
      rdata_o <= rd_i ? next_rdata : tfs_pkg::RESET_BYTE;
    end
  end

  // control registers; reserved trigger bits never store
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      capture_trigger_select <= tfs_pkg::RESET_BYTE;
      interval_enable_reg    <= tfs_pkg::RESET_BYTE;
      irq_enable_hi          <= tfs_pkg::RESET_BYTE;
      irq_enable_lo          <= tfs_pkg::RESET_BYTE;
      sw_standby             <= 1'b0;
    end else begin
      if (standby) begin
        capture_trigger_select <= tfs_pkg::RESET_BYTE;
      end else if (wr_trig) begin
        capture_trigger_select <= wdata_i & tfs_pkg::MASK_TRIG;
      end
      if (wr_i && addr_i == tfs_pkg::OFS_ITV_EN) begin
        interval_enable_reg <= wdata_i & tfs_pkg::MASK_ITV;
      end
      if (wr_i && addr_i == tfs_pkg::OFS_IRQ_EN_HI) begin
        irq_enable_hi <= wdata_i & tfs_pkg::MASK_ITV;
      end
      if (wr_i && addr_i == tfs_pkg::OFS_IRQ_EN_LO) begin
        irq_enable_lo <= wdata_i & tfs_pkg::MASK_CAP;
      end
      if (wr_i && addr_i == tfs_pkg::OFS_STANDBY) begin
        sw_standby <= wdata_i[0];
      end
    end
  end

  // counter stops in standby so no events arise there
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch0_counter <= CNT_W'(tfs_pkg::CNT_ZERO);
      itv_and_q   <= '0;
      ch1_trig_q  <= 1'b0;
    end else begin
      if (!standby) begin
        ch0_counter <= next_counter;
      end
      itv_and_q  <= itv_and;
      ch1_trig_q <= ch1_match_trigger_i;
    end
  end

  // two stages before use; third stage only for edge detect
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      pin_s1 <= {capture_pin_d_i, capture_pin_c_i, capture_pin_b_i, capture_pin_a_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  genvar g;
  generate
    for (g = 0; g < CN; g++) begin : g_cap
      always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
          cap_reg[g] <= '0;
        end else if (cap_evt[g] && !standby) begin
          cap_reg[g] <= ch0_counter;
        end
      end
      tfs_flag u_cap_flag (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .standby_i  (standby),
        .set_i      (cap_evt[g] & ~standby),
        .rd_i       (rd_cap),
        .wr_i       (wr_cap),
        .wdata_i    (wdata_i[g]),
        .flag_o     (capture_flag[g])
      );
    end
    for (g = 0; g < IN; g++) begin : g_itv
      tfs_flag u_itv_flag (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .standby_i  (standby),
        .set_i      (itv_evt[g]),
        .rd_i       (rd_itv),
        .wr_i       (wr_itv),
        .wdata_i    (wdata_i[g]),
        .flag_o     (interval_flag[g])
      );
    end
  endgenerate

  tfs_flag u_ovf_flag (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .standby_i  (standby),
    .set_i      (ovf_evt),
    .rd_i       (rd_cap),
    .wr_i       (wr_cap),
    .wdata_i    (wdata_i[tfs_pkg::BIT_OVF]),
    .flag_o     (ch0_overflow_flag)
  );

  assign ch0_counter_o       = ch0_counter;
  assign ch0_capture_reg_a_o = cap_reg[0];
  assign ch0_capture_reg_b_o = cap_reg[1];
  assign ch0_capture_reg_c_o = cap_reg[2];
  assign ch0_capture_reg_d_o = cap_reg[3];

  // level request while any enabled flag stands
  assign irq_o = |(itv_stat_rd & irq_enable_hi) | |(cap_stat_rd & irq_enable_lo);
endmodule : tfs_top
`default_nettype wire

//--- tfs_pkg.sv
// Purpose: constants for the channel 0 trigger select and status flag block
// Assumes: 8-bit register port, 20 MHz core clock
// Notes:   offsets are local indexes on the plain register port
package tfs_pkg;
  localparam int          ADDR_W        = 4;
  localparam int          DATA_W        = 8;
  localparam int          CNT_W         = 32;
  localparam int          CAP_N         = 4;
  localparam int          ITV_N         = 4;
  localparam logic [3:0]  OFS_TRIG_SEL  = 4'h0;
  localparam logic [3:0]  OFS_ITV_STAT  = 4'h1;
  localparam logic [3:0]  OFS_CAP_STAT  = 4'h2;
  localparam logic [3:0]  OFS_ITV_EN    = 4'h3;
  localparam logic [3:0]  OFS_IRQ_EN_HI = 4'h4;
  localparam logic [3:0]  OFS_IRQ_EN_LO = 4'h5;
  localparam logic [3:0]  OFS_COUNT0    = 4'h6;
  localparam logic [3:0]  OFS_COUNT1    = 4'h7;
  localparam logic [3:0]  OFS_COUNT2    = 4'h8;
  localparam logic [3:0]  OFS_COUNT3    = 4'h9;
  localparam logic [3:0]  OFS_STANDBY   = 4'hA;
  localparam int          BIT_TRIG_A    = 0;
  localparam int          BIT_TRIG_D    = 2;
  localparam int          BIT_OVF       = 4;
  localparam int          ITV_BIT_BASE  = 10;
  localparam logic [7:0]  MASK_TRIG     = 8'h05;
  localparam logic [7:0]  MASK_ITV      = 8'h0F;
  localparam logic [7:0]  MASK_CAP      = 8'h1F;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;
  localparam logic [31:0] CNT_ONES      = 32'hFFFFFFFF;
  localparam logic [31:0] CNT_ONE       = 32'h00000001;
  localparam logic [31:0] CNT_ZERO      = 32'h00000000;
endpackage : tfs_pkg

//--- tfs_flag.sv
// Purpose: one sticky status flag with read-then-write-zero clearing
// Assumes: set pulse and bus strobes on the core clock
// Notes:   set wins over a write clear in the same cycle; standby clears even over set
`timescale 1ns/1ps
`default_nettype none
module tfs_flag (
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  input  wire logic standby_i,
  input  wire logic set_i,
  input  wire logic rd_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  output logic      flag_o
);
  logic armed;
  logic next_flag;
  logic next_armed;
  wire  clr_ok = wr_i & ~wdata_i & armed & flag_o;
  // writing 1 is ignored; only an armed write of 0 or standby clears
  assign next_flag  = set_i | (flag_o & ~clr_ok);
  // armed by a read that saw the flag set, until the next write
  assign next_armed = (rd_i & flag_o) | (armed & ~wr_i & flag_o);
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      flag_o <= 1'b0;
      armed  <= 1'b0;
    end else if (standby_i) begin
      flag_o <= 1'b0;
      armed  <= 1'b0;
    end else begin
      flag_o <= next_flag;
      armed  <= next_armed;
    end
  end
endmodule : tfs_flag
`default_nettype wire

//--- tfs_props.sv
// Purpose: port checks for tfs_top
// Assumes: one clock, async high reset
// Notes:   select bits mirrored from writes
`timescale 1ns/1ps
`default_nettype none
module tfs_props #(parameter int CNT_W = 32) (
  input wire logic             core_clk_i,
  input wire logic             rst_i,
  input wire logic [3:0]       addr_i,
  input wire logic [7:0]       wdata_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [7:0]       rdata_o,
  input wire logic             hw_standby_i,
  input wire logic             ch1_match_trigger_i,
  input wire logic [CNT_W-1:0] ch0_counter_o,
  input wire logic [CNT_W-1:0] ch0_capture_reg_a_o,
  input wire logic [CNT_W-1:0] ch0_capture_reg_b_o,
  input wire logic [CNT_W-1:0] ch0_capture_reg_c_o,
  input wire logic [CNT_W-1:0] ch0_capture_reg_d_o,
  input wire logic             irq_o
);
  logic [7:0] sel;
  logic       swsb;
  // both standby sources clear the select mirror, as in the block
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sel  <= 8'h00;
      swsb <= 1'b0;
    end else begin
      if (hw_standby_i || swsb) sel <= 8'h00;
      else if (wr_i && addr_i == 4'h0) sel <= wdata_i;
      if (wr_i && addr_i == 4'hA) swsb <= wdata_i[0];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  sequence s_rise(logic b);
    $rose(ch1_match_trigger_i) && !hw_standby_i && !swsb && b;
  endsequence
  a_trig_rsv_zero: assert property (rd_i && addr_i == 4'h0 |=>
    (rdata_o & 8'hFA) == 8'h00) else $error("select reserved bit set");
  a_itv_rsv_zero: assert property (rd_i && addr_i == 4'h1 |=>
    rdata_o[7:4] == 4'h0) else $error("interval reserved bits set");
  a_cap_rsv_zero: assert property (rd_i && addr_i == 4'h2 |=>
    rdata_o[7:5] == 3'h0) else $error("capture reserved bits set");
  a_counter_wrap: assert property (&ch0_counter_o && !hw_standby_i && !swsb |=>
    !(|ch0_counter_o)) else $error("counter did not wrap");
  a_standby_quiet: assert property (hw_standby_i [*2] |-> !irq_o)
    else $error("irq during standby");
  a_sel_d_match: assert property (s_rise(sel[2]) |=>
    ch0_capture_reg_d_o == $past(ch0_counter_o)) else $error("match missed d");
  a_sel_a_match: assert property (s_rise(sel[0]) |=>
    ch0_capture_reg_a_o == $past(ch0_counter_o)) else $error("match missed a");
  a_cap_gets_count: assert property ($changed(ch0_capture_reg_a_o) |->
    ch0_capture_reg_a_o == $past(ch0_counter_o)) else $error("capture a wrong");
  a_cap_b_count: assert property ($changed(ch0_capture_reg_b_o) |->
    ch0_capture_reg_b_o == $past(ch0_counter_o)) else $error("capture b wrong");
  a_cap_c_count: assert property ($changed(ch0_capture_reg_c_o) |->
    ch0_capture_reg_c_o == $past(ch0_counter_o)) else $error("capture c wrong");
endmodule : tfs_props
`default_nettype wire

//--- tfs_trig_src.sv
// Purpose: pins and channel 1 match source
// Assumes: requests from bench on core clock
// Notes:   registered, so requests land one edge later
`timescale 1ns/1ps
`default_nettype none
module tfs_trig_src (
  input  wire logic       core_clk_i,
  input  wire logic       fire_i,
  input  wire logic [3:0] pins_i,
  output logic            match_o,
  output logic [3:0]      pins_o
);
  always_ff @(posedge core_clk_i) begin
    match_o <= fire_i;
    pins_o  <= pins_i;
  end
endmodule : tfs_trig_src
`default_nettype wire

//--- timer_ch0_trigger_and_status_flags_test.sv
// Purpose: register level bench for tfs_top
// Assumes: 20 MHz clock
// Notes:   counter cut to 14 bits so overflow is reachable
`timescale 1ns/1ps
`default_nettype none
module timer_ch0_trigger_and_status_flags_test;
  logic        clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, stby = 1'h0, fire = 1'h0;
  logic [3:0]  addr = 4'h0, pins = 4'h0, pin_o;
  logic [7:0]  wdata = 8'h00, rdata;
  logic [13:0] cnt, c;
  logic        match, irq;
  int          fails = 0, checks = 0, cyc = 0;
  always #25 clk = ~clk;
  tfs_trig_src tfs_trig_src_inst (.core_clk_i(clk), .fire_i(fire), .pins_i(pins),
    .match_o(match), .pins_o(pin_o));
  tfs_top #(.CNT_W(14)) tfs_top_inst (.core_clk_i(clk), .rst_i(rst), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .hw_standby_i(stby),
    .capture_pin_a_i(pin_o[0]), .capture_pin_b_i(pin_o[1]), .capture_pin_c_i(pin_o[2]),
    .capture_pin_d_i(pin_o[3]), .ch1_match_trigger_i(match), .ch0_counter_o(cnt),
    .ch0_capture_reg_a_o(), .ch0_capture_reg_b_o(), .ch0_capture_reg_c_o(),
    .ch0_capture_reg_d_o(), .irq_o(irq));
  task automatic end_sim;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask : wr_reg
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1;
    chk(n, e, rdata);
  endtask : rd_chk
  task automatic pulse;
    @(posedge clk);
    fire <= 1'h1;
    @(posedge clk);
    fire <= 1'h0;
  endtask : pulse
  // bounded: timeout still guards a stuck counter
  task automatic wait_cnt(input logic [13:0] m);
    for (int i = 0; i < 20000 && (cnt & m) !== m; i++) @(posedge clk) #1;
  endtask : wait_cnt
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd_chk(4'h0, 8'h00, "sel");
    rd_chk(4'h1, 8'h00, "itv");
    rd_chk(4'h2, 8'h00, "cap");
    rd_chk(4'hF, 8'h00, "unmapped");
    wr_reg(4'h3, 8'h0F);
    for (int k = 0; k < 4; k++) begin
      wait_cnt(14'h1 << (10 + k));
      rd_chk(4'h1, 8'((16'h1 << (k + 1)) - 1), "itv");
    end
    chk("irq itv mask", 8'h00, {7'h0, irq});
    wr_reg(4'h4, 8'h01);
    #1;
    chk("irq itv", 8'h01, {7'h0, irq});
    wr_reg(4'h3, 8'h00);
    wr_reg(4'h1, 8'h00);
    rd_chk(4'h1, 8'h00, "itv clr");
    chk("irq itv clr", 8'h00, {7'h0, irq});
    wr_reg(4'h4, 8'h00);
    $display("interval test done");
    wr_reg(4'h0, 8'h05);
    rd_chk(4'h0, 8'h05, "sel rsv");
    wr_reg(4'h5, 8'h1F);
    pulse;
    rd_chk(4'h2, 8'h09, "match");
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(4'h2, 8'h1F);
    wr_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h09, "no clr");
    pulse;
    addr <= 4'h2;
    wdata <= 8'h00;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    rd_chk(4'h2, 8'h09, "set wins");
    wr_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00, "clr");
    chk("irq", 8'h00, {7'h0, irq});
    $display("match test done");
    wr_reg(4'h0, 8'h00);
    pulse;
    rd_chk(4'h2, 8'h00, "no match");
    @(posedge clk);
    pins <= 4'hF;
    repeat (6) @(posedge clk);
    rd_chk(4'h2, 8'h0F, "pins");
    chk("irq", 8'h01, {7'h0, irq});
    wr_reg(4'h5, 8'h00);
    #1;
    chk("irq mask", 8'h00, {7'h0, irq});
    wr_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00, "pins clr");
    $display("pin test done");
    wait_cnt(14'h3FFF);
    rd_chk(4'h2, 8'h10, "ovf");
    wr_reg(4'h2, 8'h00);
    rd_chk(4'h2, 8'h00, "ovf clr");
    $display("overflow test done");
    wr_reg(4'h5, 8'h1F);
    wr_reg(4'h0, 8'h05);
    pulse;
    @(posedge clk);
    stby <= 1'h1;
    #1;
    chk("irq pre stby", 8'h01, {7'h0, irq});
    repeat (3) @(posedge clk);
    stby <= 1'h0;
    rd_chk(4'h2, 8'h00, "stby cap");
    rd_chk(4'h0, 8'h00, "stby sel");
    $display("standby test done");
    @(posedge clk);
    pins <= 4'h0;
    wr_reg(4'hA, 8'h01);
    rd_chk(4'hA, 8'h01, "sw stby");
    c = cnt;
    @(posedge clk);
    pins <= 4'hF;
    repeat (6) @(posedge clk);
    rd_chk(4'h2, 8'h00, "sw stby cap");
    rd_chk(4'h6, c[7:0], "cnt byte0");
    rd_chk(4'h7, {2'h0, c[13:8]}, "cnt byte1");
    rd_chk(4'h8, 8'h00, "cnt byte2");
    chk("cnt frozen", c[7:0], cnt[7:0]);
    wr_reg(4'hA, 8'h00);
    $display("sw standby test done");
    end_sim;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      end_sim;
    end
  end
endmodule : timer_ch0_trigger_and_status_flags_test
bind tfs_top tfs_props #(.CNT_W(CNT_W)) tfs_props_inst (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .hw_standby_i(hw_standby_i), .ch1_match_trigger_i(ch1_match_trigger_i),
  .ch0_counter_o(ch0_counter_o), .ch0_capture_reg_a_o(ch0_capture_reg_a_o),
  .ch0_capture_reg_b_o(ch0_capture_reg_b_o), .ch0_capture_reg_c_o(ch0_capture_reg_c_o),
  .ch0_capture_reg_d_o(ch0_capture_reg_d_o), .irq_o(irq_o));
`default_nettype wire
